// ---- sfs_status.v ----
// Status, event and interrupt logic of a serial port, with its AHB-Lite register slave.
// Assumes the shifter and FIFO storage sit outside; link pins arrive asynchronously.
// Behaviour
// [R01] Eight-bit writable DMA master receive byte count.
// [R02] Early chip select release sets abort flag.
// [R03] Status read clears event and summary flags.
// [R04] Excess flag tracks fill above threshold.
// [R05] Receive fill level reported in bits 10:8.
// [R06] Transmit fill level reported in bits 3:1.
// [R07] Byte into full receive FIFO flags overflow.
// [R08] Receive threshold reached sets receive event.
// [R09] Transmit threshold reached sets transmit event.
// [R10] Transfer with empty transmit FIFO flags underrun.
// [R11] Any port interrupt sets summary flag.
// [R12] Threshold code n means n+1 bytes.
// [R13] Transfer starts on write or idle read.
// [R14] Event coinciding with clearing read survives.
//
// Register access over AHB-Lite is this design's own decision.
`include "sfs_regs.vh"
module sfs_status (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire        spi_sclk,
  input  wire        spi_cs_n,
  input  wire [7:0]  rx_fifo_rdata,
  output wire        rx_fifo_pop,
  output wire        tx_fifo_push,
  output wire [7:0]  tx_fifo_wdata,
  output wire        xfer_start,
  output wire [7:0]  dma_rx_remaining,
  output wire        irq
);
  reg  [31:0] hrdata_ff;
  reg  [31:0] nxt_hrdata;
  reg         wr_pend_ff;
  reg  [31:0] wr_addr_ff;
  reg  [6:0]  ctrl_ff;
  reg  [12:0] mask_ff;
  reg  [7:0]  cnt_ff;
  reg  [7:0]  remain_ff;
  reg  [7:0]  txdata_ff;
  reg         pop_ff;
  reg         push_ff;
  reg         start_ff;
  reg  [2:0]  rxlvl_ff;
  reg  [2:0]  txlvl_ff;
  reg  [1:0]  rxbytes_ff;
  reg  [1:0]  txbytes_ff;
  reg  [2:0]  bitcnt_ff;
  reg         sclk_d_ff;
  reg         cs_d_ff;
  reg         csab_ff;
  reg         receive_overflow_flag_ff;
  reg         rxev_ff;
  reg         txev_ff;
  reg         transmit_underrun_flag_ff;
  reg         sum_ff;
  wire [1:0]  pins;
  wire        sclk_s;
  wire        cs_s;
  wire        acc;
  wire        rd_acc;
  wire        rd_status;
  wire        rd_rx;
  wire        wr_tx;
  wire        wr_en;
  wire        sclk_rise;
  wire        cs_rise;
  wire        bit_edge;
  wire        byte_first;
  wire        byte_done;
  wire        rx_arrive;
  wire        rx_pop_now;
  wire        tx_push_now;
  wire        tx_pop_now;
  wire        link_idle;
  wire [1:0]  thr;
  wire        trig_tx;
  wire        receive_flush;
  wire        transmit_flush;
  wire        dma_en;
  wire        ev_csab;
  wire        ev_receive_overflow_flag;
  wire        ev_rxev;
  wire        ev_txev;
  wire        ev_transmit_underrun_flag;
  wire        irq_any;
  wire        excess;
  wire [15:0] status_word;
  wire [12:0] irq_lines;

  // Link pins cross into hclk through two flops before any edge logic sees them.
  sfs_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({spi_sclk, spi_cs_n}),
    .sync_out (pins)
  );
  assign sclk_s = pins[1];
  assign cs_s   = pins[0];

  assign thr     = ctrl_ff[`SFS_CT_THR_HI:`SFS_CT_THR_LO];
  assign trig_tx = ctrl_ff[`SFS_CT_TRIG];
  assign receive_flush  = ctrl_ff[`SFS_CT_RECEIVE_FLUSH];
  assign transmit_flush  = ctrl_ff[`SFS_CT_TRANSMIT_FLUSH];
  assign dma_en  = ctrl_ff[`SFS_CT_DMA];

  // Zero wait-state slave: reads answer from the address phase, writes land in the data phase.
  assign acc       = hsel & hready & htrans[1];
  assign rd_acc    = acc & ~hwrite;
  assign rd_status = rd_acc & (haddr == `SFS_ADDR_STATUS);
  assign rd_rx     = rd_acc & (haddr == `SFS_ADDR_RXDATA);
  assign wr_en     = wr_pend_ff;
  assign wr_tx     = wr_en & (wr_addr_ff == `SFS_ADDR_TXDATA) & ~transmit_flush;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // Link edge detection runs on synchronised copies only.
  assign sclk_rise  = sclk_s & ~sclk_d_ff;
  assign cs_rise    = cs_s & ~cs_d_ff;
  assign bit_edge   = sclk_rise & ~cs_s;
  assign byte_first = bit_edge & (bitcnt_ff == 3'h0);
  assign byte_done  = bit_edge & (bitcnt_ff == `SFS_BYTE_BITS);
  assign link_idle  = cs_s & (bitcnt_ff == 3'h0);

  // Flushing receive drops incoming bytes so the level never grows.
  assign rx_arrive   = byte_done & ~receive_flush;
  assign rx_pop_now  = rd_rx & (rxlvl_ff != 3'h0);
  assign tx_push_now = wr_tx & (txlvl_ff != `SFS_FIFO_DEPTH);
  assign tx_pop_now  = byte_done & (txlvl_ff != 3'h0);

  // [R02] Abort on early release.
  assign ev_csab = cs_rise & (bitcnt_ff != 3'h0);
  // [R07] Overflow on full FIFO.
  assign ev_receive_overflow_flag = byte_done & (rxlvl_ff == `SFS_FIFO_DEPTH);
  // [R08] [R12] Receive threshold count.
  assign ev_rxev = rx_arrive & ~trig_tx & (rxbytes_ff == thr);
  // [R09] [R12] Transmit threshold count.
  assign ev_txev = byte_done & trig_tx & (txbytes_ff == thr);
  // [R10] Underrun at byte start.
  assign ev_transmit_underrun_flag = byte_first & (txlvl_ff == 3'h0);

  // [R04] Excess over threshold.
  assign excess = (rxlvl_ff > ({1'b0, thr} + 3'h1));

  // Per-bit interrupt gating: flushing silences overflow/underrun, DMA silences events.
  assign irq_lines = {csab_ff, 4'h0, receive_overflow_flag_ff & ~receive_flush, rxev_ff & ~dma_en,
                      txev_ff & ~dma_en, transmit_underrun_flag_ff & ~transmit_flush, 3'h0, 1'b0};
  // [R11] Summary source.
  assign irq_any = ev_csab | (ev_receive_overflow_flag & ~receive_flush) | ((ev_rxev | ev_txev) & ~dma_en)
                 | (ev_transmit_underrun_flag & ~transmit_flush);
  assign irq     = |((irq_lines | {12'h000, sum_ff}) & mask_ff);

  // [R05] [R06] Status word assembly.
  assign status_word = {3'h0, csab_ff, excess, rxlvl_ff, receive_overflow_flag_ff, rxev_ff, txev_ff,
                        transmit_underrun_flag_ff, txlvl_ff, sum_ff};

  // Read mux; unmapped and write-only addresses read as zero.
  always @* begin
    nxt_hrdata = 32'h00000000;
    case (haddr)
      `SFS_ADDR_DMA_CNT: nxt_hrdata = {24'h000000, cnt_ff};
      `SFS_ADDR_STATUS:  nxt_hrdata = {16'h0000, status_word};
      `SFS_ADDR_RXDATA:  nxt_hrdata = {24'h000000, rx_fifo_rdata};
      `SFS_ADDR_CTRL:    nxt_hrdata = {25'h0000000, ctrl_ff};
      `SFS_ADDR_MASK:    nxt_hrdata = {19'h00000, mask_ff};
      default:           nxt_hrdata = 32'h00000000;
    endcase
  end

  // Bus capture, software registers and datapath strobes.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff  <= 32'h00000000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h00000000;
      ctrl_ff    <= `SFS_CTRL_RESET;
      mask_ff    <= `SFS_MASK_RESET;
      cnt_ff     <= `SFS_CNT_RESET;
      txdata_ff  <= 8'h00;
      pop_ff     <= 1'b0;
      push_ff    <= 1'b0;
      start_ff   <= 1'b0;
    end else begin
      wr_pend_ff <= acc & hwrite;
      if (acc & hwrite) begin
        wr_addr_ff <= haddr;
      end
      if (rd_acc) begin
        hrdata_ff <= rx_pop_now | ~rd_rx ? nxt_hrdata : 32'h00000000;
      end
      // [R01] Count register write.
      if (wr_en & (wr_addr_ff == `SFS_ADDR_DMA_CNT)) begin
        cnt_ff <= hwdata[7:0];
      end
      if (wr_en & (wr_addr_ff == `SFS_ADDR_CTRL)) begin
        ctrl_ff <= hwdata[6:0];
      end
      if (wr_en & (wr_addr_ff == `SFS_ADDR_MASK)) begin
        mask_ff <= hwdata[12:0];
      end
      if (wr_tx) begin
        txdata_ff <= hwdata[7:0];
      end
      pop_ff  <= rx_pop_now;
      push_ff <= tx_push_now;
      // [R13] Transfer start trigger.
      start_ff <= trig_tx ? wr_tx : (rd_rx & link_idle);
    end
  end

  // [R01] DMA master receive countdown, loaded only in DMA master receive mode.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remain_ff <= 8'h00;
    end else if (dma_en & ctrl_ff[`SFS_CT_MASTER] & ~trig_tx & rd_rx & link_idle) begin
      remain_ff <= cnt_ff;
    end else if (byte_done & (remain_ff != 8'h00)) begin
      remain_ff <= remain_ff - 8'h01;
    end
  end

  // Link tracking: bit counter resets on every chip select release.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_d_ff <= 1'b1;
      cs_d_ff   <= 1'b1;
      bitcnt_ff <= 3'h0;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_s;
      if (cs_s) begin
        bitcnt_ff <= 3'h0;
      end else if (bit_edge) begin
        bitcnt_ff <= bitcnt_ff + 3'h1;
      end
    end
  end

  // [R05] [R06] Fill levels and threshold byte counters.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxlvl_ff   <= 3'h0;
      txlvl_ff   <= 3'h0;
      rxbytes_ff <= 2'h0;
      txbytes_ff <= 2'h0;
    end else begin
      if (rx_arrive & ~ev_receive_overflow_flag & ~rx_pop_now) begin
        rxlvl_ff <= rxlvl_ff + 3'h1;
      end else if (rx_pop_now & ~(rx_arrive & ~ev_receive_overflow_flag)) begin
        rxlvl_ff <= rxlvl_ff - 3'h1;
      end
      if (tx_push_now & ~tx_pop_now) begin
        txlvl_ff <= txlvl_ff + 3'h1;
      end else if (tx_pop_now & ~tx_push_now) begin
        txlvl_ff <= txlvl_ff - 3'h1;
      end
      // [R12] Wrap at threshold.
      if (rx_arrive & ~trig_tx) begin
        rxbytes_ff <= (rxbytes_ff == thr) ? 2'h0 : rxbytes_ff + 2'h1;
      end
      if (byte_done & trig_tx) begin
        txbytes_ff <= (txbytes_ff == thr) ? 2'h0 : txbytes_ff + 2'h1;
      end
    end
  end

  // Sticky flags: a status read clears, a same-cycle event sets, and the set wins.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csab_ff <= 1'b0;
      receive_overflow_flag_ff <= 1'b0;
      rxev_ff <= 1'b0;
      txev_ff <= 1'b0;
      transmit_underrun_flag_ff <= 1'b0;
      sum_ff  <= 1'b0;
    end else begin
      // [R03] [R14] Clear on read.
      csab_ff <= ev_csab | (csab_ff & ~rd_status);
      receive_overflow_flag_ff <= ev_receive_overflow_flag | (receive_overflow_flag_ff & ~rd_status);
      rxev_ff <= ev_rxev | (rxev_ff & ~rd_status);
      txev_ff <= ev_txev | (txev_ff & ~rd_status);
      transmit_underrun_flag_ff <= ev_transmit_underrun_flag | (transmit_underrun_flag_ff & ~rd_status);
      // [R11] Summary flag.
      sum_ff  <= irq_any | (sum_ff & ~rd_status);
    end
  end

  assign rx_fifo_pop      = pop_ff;
  assign tx_fifo_push     = push_ff;
  assign tx_fifo_wdata    = txdata_ff;
  assign xfer_start       = start_ff;
  assign dma_rx_remaining = remain_ff;
endmodule

// ---- sfs_regs.vh ----
// Register offsets, field positions and reset values of the serial port status block.
// Assumes a 32-bit AHB-Lite byte address bus; all offsets are full byte addresses.
`ifndef SFS_REGS_VH
`define SFS_REGS_VH

`define SFS_ADDR_DMA_CNT   32'h40004018
`define SFS_ADDR_STATUS    32'h40004400
`define SFS_ADDR_RXDATA    32'h40004404
`define SFS_ADDR_TXDATA    32'h40004408
`define SFS_ADDR_CTRL      32'h40004410
`define SFS_ADDR_MASK      32'h40004414

`define SFS_ST_CSABORT     12
`define SFS_ST_EXCESS      11
`define SFS_ST_RXLVL_HI    10
`define SFS_ST_RXLVL_LO    8
`define SFS_ST_RECEIVE_OVERFLOW_FLAG        7
`define SFS_ST_RXEV        6
`define SFS_ST_TXEV        5
`define SFS_ST_TRANSMIT_UNDERRUN_FLAG        4
`define SFS_ST_TXLVL_HI    3
`define SFS_ST_TXLVL_LO    1
`define SFS_ST_IRQ         0

`define SFS_CT_THR_HI      1
`define SFS_CT_THR_LO      0
`define SFS_CT_TRIG        2
`define SFS_CT_RECEIVE_FLUSH      3
`define SFS_CT_TRANSMIT_FLUSH      4
`define SFS_CT_DMA         5
`define SFS_CT_MASTER      6

`define SFS_CTRL_RESET     7'h00
`define SFS_MASK_RESET     13'h0000
`define SFS_CNT_RESET      8'h00
`define SFS_FIFO_DEPTH     3'h4
`define SFS_BYTE_BITS      3'h7

`endif

// ---- sfs_sync.v ----
// Two flip-flop level synchroniser for pins arriving from outside the hclk domain.
// Assumes the inputs are levels; the first stage is read only by the second.
module sfs_sync #(
  parameter WIDTH = 2
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // Reset value is all ones so idle-high pins do not show a false edge.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= {WIDTH{1'b1}};
      sync_ff <= {WIDTH{1'b1}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ---- sfs_status_sva.sv ----
// Checker of the serial port status block, watching only its top-level ports.
// Assumes zero-wait AHB-Lite answers and link pins from outside the hclk domain.
`include "sfs_regs.vh"
module sfs_status_sva (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        spi_cs_n,
  input logic        rx_fifo_pop,
  input logic        tx_fifo_push,
  input logic        xfer_start,
  input logic        irq
);
  // Taken accesses, split by kind.
  wire acc    = hsel & hready & htrans[1];
  wire st_rd  = acc & !hwrite & (haddr == `SFS_ADDR_STATUS);
  wire cnt_rd = acc & !hwrite & (haddr == `SFS_ADDR_DMA_CNT);
  wire rx_rd  = acc & !hwrite & (haddr == `SFS_ADDR_RXDATA);
  wire tx_wr  = acc & hwrite & (haddr == `SFS_ADDR_TXDATA);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_cnt_width; cnt_rd |=> hrdata[31:8] == 24'h0; endproperty
  a_cnt_width: assert property (p_cnt_width) else $error("count wider than a byte");
  property p_rx_lvl; st_rd |=> hrdata[31:13] == 19'h0 && hrdata[10:8] <= 3'h4; endproperty
  a_rx_lvl: assert property (p_rx_lvl) else $error("bad receive level field");
  property p_tx_lvl; st_rd |=> hrdata[3:1] <= 3'h4; endproperty
  a_tx_lvl: assert property (p_tx_lvl) else $error("bad transmit level field");
  property p_excess; st_rd |=> !hrdata[11] || hrdata[10:8] >= 3'h2; endproperty
  a_excess: assert property (p_excess) else $error("excess with under two bytes");
  property p_summary; st_rd && irq |=> hrdata[0]; endproperty
  a_summary: assert property (p_summary) else $error("irq without summary flag");
  // The quiet window keeps a late chip select abort from landing after the read.
  property p_clear; spi_cs_n [*7] ##0 st_rd |=> !irq; endproperty
  a_clear: assert property (p_clear) else $error("irq kept after status read");
  property p_pop; rx_fifo_pop |-> $past(rx_rd); endproperty
  a_pop: assert property (p_pop) else $error("pop without receive read");
  property p_push; tx_fifo_push |-> $past(tx_wr) || $past(tx_wr, 2); endproperty
  a_push: assert property (p_push) else $error("push without transmit write");
  property p_start; xfer_start |-> $past(rx_rd) || $past(tx_wr) || $past(tx_wr, 2); endproperty
  a_start: assert property (p_start) else $error("start without trigger access");
endmodule

bind sfs_status sfs_status_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .spi_cs_n(spi_cs_n),
  .rx_fifo_pop(rx_fifo_pop), .tx_fifo_push(tx_fifo_push), .xfer_start(xfer_start), .irq(irq)
);

// ---- sfs_link_model.sv ----
// Behavioural link master that frames bytes on the serial pins.
// Assumes the block samples both pins with its own clock; sclk rests low between frames.
module sfs_link_model (
  output logic sclk,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins rest idle so no bit is counted outside a frame.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // A frame shorter than eight bits is how an abort is provoked.
  task automatic frame(input int bits);
    #13 cs_n = 1'b0;
    #32;
    repeat (bits) begin
      sclk = 1'b1;
      #32 sclk = 1'b0;
      #32;
    end
    cs_n = 1'b1;
    #96;
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench of the serial port status block with a behavioural link master.
// Assumes zero-wait AHB-Lite answers; every wait is bounded.
`include "sfs_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, xs = 32'h0;
  logic [7:0]  rxd = 8'h00, cv = 8'h00;
  logic [16:0] rnd = 17'h164E0;
  wire  [31:0] hrdata;
  wire         hready, sclk, cs_n, xfer_start, irq, hresp;
  wire  [7:0]  txw, rem;
  int          mismatches = 0, checks = 0, i;
  always #2 hclk = ~hclk;
  // Starts are counted so that bus triggers can be compared later.
  always @(posedge hclk) if (xfer_start === 1'b1) xs <= xs + 32'h1;
  sfs_link_model link (.sclk(sclk), .cs_n(cs_n));
  sfs_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .rx_fifo_rdata(rxd), .rx_fifo_pop(), .tx_fifo_push(), .tx_fifo_wdata(txw),
    .xfer_start(xfer_start), .dma_rx_remaining(rem), .irq(irq));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // Expected status word from its fields, high flags first.
  function automatic logic [31:0] st(input logic [1:0] ce, input logic [2:0] rl,
                                     input logic [3:0] ev, input logic [2:0] tl, input logic s);
    return {19'h0, ce, rl, ev, tl, s};
  endfunction
  task automatic give_verdict;
    $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask
  // A hung bus counts as a mismatch and closes the run.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 40) begin
        mismatches++;
        give_verdict;
      end
      @(posedge hclk);
    end
  endtask
  // One single AHB-Lite transfer; entered just after a rising edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(q, exp, m);
  endtask
  task automatic fr(input int n);
    link.frame(n);
    @(posedge hclk);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(`SFS_ADDR_DMA_CNT, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, hresp}, 32'h0, 32'h1);
    rc(`SFS_ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
    rc(32'h4000441C, 32'h0, 32'hFFFFFFFF);
    rnd = lfsr(rnd);
    bus(1'b1, `SFS_ADDR_DMA_CNT, {15'h7FFF, rnd});
    rc(`SFS_ADDR_DMA_CNT, {24'h0, rnd[7:0]}, 32'hFFFFFFFF);
    rnd = lfsr(rnd);
    rxd <= rnd[7:0];
    bus(1'b1, `SFS_ADDR_CTRL, 32'h4);
    bus(1'b1, `SFS_ADDR_MASK, 32'h1FFF);
    bus(1'b1, `SFS_ADDR_TXDATA, {15'h0, rnd});
    bus(1'b1, `SFS_ADDR_TXDATA, {24'h0, rnd[15:8]});
    rc(`SFS_ADDR_STATUS, st(2'h0, 3'h0, 4'h0, 3'h2, 1'b0), 32'hFFFFFFFF);
    chk({24'h0, txw}, {24'h0, rnd[15:8]}, 32'hFF);
    chk(xs, 32'h2, 32'hFFFFFFFF);
    fr(8);
    chk({31'h0, irq}, 32'h1, 32'h1);
    rc(`SFS_ADDR_STATUS, st(2'h0, 3'h1, 4'h2, 3'h1, 1'b1), 32'hFFFFFFFF);
    rc(`SFS_ADDR_STATUS, st(2'h0, 3'h1, 4'h0, 3'h1, 1'b0), 32'hFFFFFFFF);
    chk({31'h0, irq}, 32'h0, 32'h1);
    fr(8);
    rc(`SFS_ADDR_STATUS, st(2'h1, 3'h2, 4'h2, 3'h0, 1'b1), 32'hFFFFFFFF);
    fr(8);
    rc(`SFS_ADDR_STATUS, st(2'h1, 3'h3, 4'h3, 3'h0, 1'b1), 32'hFFFFFFFF);
    fr(8);
    fr(8);
    rc(`SFS_ADDR_STATUS, st(2'h1, 3'h4, 4'hB, 3'h0, 1'b1), 32'hFFFFFFFF);
    fr(3);
    rc(`SFS_ADDR_STATUS, st(2'h3, 3'h4, 4'h1, 3'h0, 1'b1), 32'hFFFFFFFF);
    for (i = 0; i < 5; i++) begin
      rc(`SFS_ADDR_RXDATA, (i < 4) ? {24'h0, rxd} : 32'h0, 32'hFFFFFFFF);
    end
    rc(`SFS_ADDR_STATUS, 32'h0, 32'h0F00);
    bus(1'b1, `SFS_ADDR_CTRL, 32'h1);
    rc(`SFS_ADDR_RXDATA, 32'h0, 32'hFFFFFFFF);
    fr(8);
    chk(xs, 32'h3, 32'hFFFFFFFF);
    rc(`SFS_ADDR_STATUS, st(2'h0, 3'h1, 4'h0, 3'h0, 1'b0), 32'h0F40);
    fr(8);
    rc(`SFS_ADDR_STATUS, st(2'h0, 3'h2, 4'h4, 3'h0, 1'b0), 32'h0F40);
    bus(1'b1, `SFS_ADDR_MASK, 32'h40);
    bus(1'b1, `SFS_ADDR_CTRL, 32'h21);
    fr(8);
    fr(8);
    chk({31'h0, irq}, 32'h0, 32'h1);
    bus(1'b1, `SFS_ADDR_CTRL, 32'h1);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h1, 32'h1);
    // DMA master receive: an idle receive read loads the count, each byte takes one off.
    rnd = lfsr(rnd);
    cv = {1'b1, rnd[6:0]};
    bus(1'b1, `SFS_ADDR_DMA_CNT, {24'h0, cv});
    bus(1'b1, `SFS_ADDR_CTRL, 32'h60);
    rc(`SFS_ADDR_RXDATA, {24'h0, rxd}, 32'hFFFFFFFF);
    @(posedge hclk);
    chk(xs, 32'h4, 32'hFFFFFFFF);
    chk({24'h0, rem}, {24'h0, cv}, 32'hFF);
    fr(8);
    chk({24'h0, rem}, {24'h0, cv - 8'h01}, 32'hFF);
    give_verdict;
  end
endmodule
